// ==== sei_consts.svh ====
`ifndef SEI_CONSTS_SVH
`define SEI_CONSTS_SVH

// ----------------------------------------
// bus timing, in ns and in 40 MHz cycles
// ----------------------------------------
`define SEI_CLK_PERIOD_NS 25
`define SEI_T_LOW_NS 1300
`define SEI_T_HIGH_NS 600
`define SEI_T_HD_DAT_NS 300
`define SEI_T_BUF_NS 1300
// least times round up to whole cycles
`define SEI_LOW_CYC ((`SEI_T_LOW_NS + `SEI_CLK_PERIOD_NS - 1) / `SEI_CLK_PERIOD_NS)
`define SEI_HIGH_CYC ((`SEI_T_HIGH_NS + `SEI_CLK_PERIOD_NS - 1) / `SEI_CLK_PERIOD_NS)
`define SEI_HOLD_CYC ((`SEI_T_HD_DAT_NS + `SEI_CLK_PERIOD_NS - 1) / `SEI_CLK_PERIOD_NS)
`define SEI_BUF_CYC ((`SEI_T_BUF_NS + `SEI_CLK_PERIOD_NS - 1) / `SEI_CLK_PERIOD_NS)

// ----------------------------------------
// control byte and page layout
// ----------------------------------------
`define SEI_CTRL_CODE 4'ha
`define SEI_IGNORED_SELECT 2'h0
`define SEI_PAGE_BYTES 6'h10
`define SEI_FIFO_DEPTH 16

`endif

// ==== sei_eeprom_model.sv ====
// ----------------------------------------
// behavioural two-wire eeprom at far side
// ----------------------------------------
module sei_eeprom_model #(
  parameter logic [3:0] TYPE_CODE = 4'ha,
  parameter int WRITE_CYCLES = 2000
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // resolved bus lines and write inhibit strap
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic wp_in,
  // open-drain data pull, low = pull line low
  output logic sda_oe_n_out = 1'b1
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] mem [512];
  logic [7:0] pbuf [16];
  logic [15:0] pval;
  logic [7:0] sh;
  logic [7:0] rsh;
  logic [8:0] ptr;
  logic [3:0] bits;
  logic [1:0] phase;
  logic scl_q, sda_q, act, rd_go, mack, half;
  int busy;

  // bus conditions, judged from present levels against last sampled ones
  wire start_w = scl_in && scl_q && sda_q && !sda_in;
  wire stop_w = scl_in && scl_q && !sda_q && sda_in;
  wire rise_w = scl_in && !scl_q;
  wire fall_w = !scl_in && scl_q;

  // known fill so reads of untouched places are predictable
  initial for (int i = 0; i < 512; i++) mem[i] = i[7:0] ^ 8'h5a;

  // slave engine: changes data only just after a clock fall
  always @(posedge clk_in) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (busy > 0) busy <= busy - 1;
    if (!reset_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_oe_n_out <= 1'b1;
      act <= 1'b0;
      phase <= 2'h0;
      bits <= 4'h0;
      pval <= '0;
    end else if (start_w) begin
      bits <= 4'h8; // the clock fall after START is no bit boundary
      phase <= 2'h0;
      act <= 1'b0;
      pval <= '0;
      sda_oe_n_out <= 1'b1;
    end else if (stop_w) begin
      // commit only the buffered bytes marked valid, and only with strap low
      if (phase == 2'h2 && !wp_in) begin
        for (int i = 0; i < 16; i++)
          if (pval[i]) mem[{ptr[8:4], i[3:0]}] <= pbuf[i];
        if (pval != '0) busy <= WRITE_CYCLES;
      end
      pval <= '0;
      phase <= 2'h0;
      act <= 1'b0;
      sda_oe_n_out <= 1'b1;
    end else if (rise_w) begin
      sh <= {sh[6:0], sda_in};
      if (bits == 4'h8) mack <= !sda_in;
    end else if (fall_w) begin
      bits <= (bits == 4'h8) ? 4'h0 : bits + 4'h1;
      sda_oe_n_out <= 1'b1;
      if (bits == 4'h7 && phase != 2'h3) begin
        if (phase == 2'h0 && sh[7:4] == TYPE_CODE && busy == 0) begin
          act <= 1'b1;
          sda_oe_n_out <= 1'b0;
          half <= sh[1];
          phase <= sh[0] ? 2'h3 : 2'h1;
          rd_go <= sh[0];
        end else if (act && phase == 2'h1) begin
          ptr <= {half, sh};
          sda_oe_n_out <= 1'b0;
          phase <= 2'h2;
        end else if (act && phase == 2'h2) begin
          pbuf[ptr[3:0]] <= sh;
          pval[ptr[3:0]] <= 1'b1;
          ptr[3:0] <= ptr[3:0] + 4'h1;
          sda_oe_n_out <= 1'b0;
        end
      end else if (phase == 2'h3 && act) begin
        if (bits == 4'h8 && (rd_go || mack)) begin
          rsh <= mem[ptr];
          sda_oe_n_out <= mem[ptr][7];
          ptr <= ptr + 9'h1;
          rd_go <= 1'b0;
        end else if (bits == 4'h8) begin
          act <= 1'b0;
        end else if (bits < 4'h7) begin
          sda_oe_n_out <= rsh[3'h6 - bits[2:0]];
        end
      end
    end
  end
endmodule : sei_eeprom_model

// ==== sei_fifo.sv ====
// ----------------------------------------
// write data buffer, valid/ready both sides
// ----------------------------------------
module sei_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // fill side
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  // drain side
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  wire empty = (wr_ptr == rd_ptr);
  wire push = in_valid_in && !full;
  wire pop = out_ready_in && !empty;

  // depth must be a power of two for the wrap bit to work
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem[rd_ptr[AW-1:0]];

  // storage
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end

  // pointers
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

endmodule : sei_fifo

// ==== sei_master.sv ====
// Behaviour
// - this master alone makes the clock and the START and STOP framing.
// - a new command starts only while the bus reads idle; the repeated START of a read does not check.
// - both lines high means idle; busy_out follows the engine state, not the lines.
// - START is data falling while clock high; each transfer restarts decoding.
// - STOP is data rising while clock high; it ends the operation.
// - every command not refused opens with a START.
// - every operation closes with a STOP.
// - data changes only while clock low; one bit per clock pulse.
// - a ninth clock pulse follows every byte for the acknowledge.
// - the acknowledging party holds data low over the whole ack high phase.
// - on reads the master withholds ack after the last byte, then STOPs.
// - byte write sends control, word address, then data, each acknowledged.
// - the master keeps each page write inside one page.
// - the master polls with START plus write control until acked.
`include "sei_consts.svh"

module sei_master #(
  parameter int FIFO_DEPTH = `SEI_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // command request
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic cmd_write_in,
  input wire logic [8:0] cmd_addr_in,
  input wire logic [4:0] cmd_len_in,
  // write data stream
  input wire logic [7:0] wr_data_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  // read data and status
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic done_out,
  output logic err_out,
  output logic busy_out,
  // write inhibit strap to the device
  input wire logic write_inhibit_in,
  output logic write_inhibit_out,
  // two-wire bus pins
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out
);

  // ----------------------------------------
  // timing points within one bus phase
  // ----------------------------------------
  localparam logic [7:0] LOW = 8'(`SEI_LOW_CYC);
  localparam logic [7:0] HIGH = 8'(`SEI_HIGH_CYC);
  localparam logic [7:0] HOLD = 8'(`SEI_HOLD_CYC);
  localparam logic [7:0] BUF = 8'(`SEI_BUF_CYC);

  sei_pkg::sei_state_t state;
  sei_pkg::sei_stage_t stage;
  logic [7:0] cnt;
  logic [3:0] bit_idx;
  logic [8:0] tx, rx;
  logic [4:0] left;
  logic [8:0] addr;
  logic op_write, again, failed;
  logic scl_low, sda_low;
  logic [1:0] pins_s;
  logic [7:0] fifo_data;
  logic fifo_valid;

  // ----------------------------------------
  // pin synchronisers and write buffer
  // ----------------------------------------
  sei_sync #(.WIDTH(2)) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .d_in({scl_in, sda_in}),
    .q_out(pins_s)
  );

  wire scl_s = pins_s[1];
  wire sda_s = pins_s[0];
  wire fifo_pop = (state == sei_pkg::SEI_LOAD) && (stage == sei_pkg::SEI_ST_WDATA) && fifo_valid;
  sei_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_data_in(wr_data_in),
    .in_valid_in(wr_valid_in),
    .in_ready_out(wr_ready_out),
    .out_data_out(fifo_data),
    .out_valid_out(fifo_valid),
    .out_ready_in(fifo_pop)
  );

  // ----------------------------------------
  // decode of phase points and conditions
  // ----------------------------------------
  wire at_zero = (cnt == 8'h00);
  wire at_hold = (cnt == HOLD);
  wire at_rise = (cnt == LOW);
  wire at_mid = (cnt == 8'(LOW + HIGH));
  wire bit_end = (cnt == 8'(LOW + HIGH - 8'h01));
  wire start_end = (cnt == 8'(LOW + HIGH + HIGH - 8'h01));
  wire stop_end = (cnt == 8'(LOW + HIGH + BUF - 8'h01));
  wire bus_idle = scl_s && sda_s;
  wire cmd_fire = (state == sei_pkg::SEI_IDLE) && cmd_valid_in && bus_idle;
  wire [5:0] page_sum = 6'(cmd_addr_in[3:0]) + 6'(cmd_len_in);
  // refusing a crossing write beats silently wrapping onto old data
  wire page_cross = (page_sum > `SEI_PAGE_BYTES) || (cmd_len_in == 5'h00);
  wire stage_rd = (stage == sei_pkg::SEI_ST_CTRL_R);
  wire [7:0] ctrl_byte = {`SEI_CTRL_CODE, `SEI_IGNORED_SELECT, addr[8], stage_rd};
  wire is_ctrl = (stage == sei_pkg::SEI_ST_CTRL_W) || (stage == sei_pkg::SEI_ST_POLL) || stage_rd;
  wire last = (left == 5'h01);
  wire nack = sda_s;
  wire [8:0] rx_next = {rx[7:0], sda_s};
  wire load_go = (state == sei_pkg::SEI_LOAD) && ((stage != sei_pkg::SEI_ST_WDATA) || fifo_valid);
  // the ninth bit is released by a transmitter, and is ack/no-ack when reading
  wire [8:0] next_tx = is_ctrl ? {ctrl_byte, 1'b1} :
                       (stage == sei_pkg::SEI_ST_ADDR) ? {addr[7:0], 1'b1} :
                       (stage == sei_pkg::SEI_ST_WDATA) ? {fifo_data, 1'b1} :
                       {8'hff, last};

  // ----------------------------------------
  // pin drive: open drain, enable low pulls the line
  // ----------------------------------------
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe_n_out = !scl_low;
  assign sda_oe_n_out = !sda_low;
  assign cmd_ready_out = (state == sei_pkg::SEI_IDLE) && bus_idle;
  assign busy_out = (state != sei_pkg::SEI_IDLE);

  // write inhibit follows software, registered toward the pin
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      write_inhibit_out <= 1'b0;
    end else begin
      write_inhibit_out <= write_inhibit_in;
    end
  end

  // ----------------------------------------
  // bus engine
  // ----------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= sei_pkg::SEI_IDLE;
      stage <= sei_pkg::SEI_ST_CTRL_W;
      cnt <= 8'h00;
      bit_idx <= 4'h0;
      tx <= 9'h1ff;
      rx <= 9'h000;
      left <= 5'h00;
      addr <= 9'h000;
      op_write <= 1'b0;
      again <= 1'b0;
      failed <= 1'b0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      rd_data_out <= 8'h00;
      rd_valid_out <= 1'b0;
      done_out <= 1'b0;
      err_out <= 1'b0;
    end else begin
      rd_valid_out <= 1'b0;
      done_out <= 1'b0;
      err_out <= 1'b0;
      cnt <= 8'(cnt + 8'h01);
      case (state)
        sei_pkg::SEI_IDLE: begin
          cnt <= 8'h00;
          if (cmd_fire && cmd_write_in && page_cross) begin
            err_out <= 1'b1;
          end else if (cmd_fire) begin
            op_write <= cmd_write_in;
            addr <= cmd_addr_in;
            left <= cmd_len_in;
            stage <= sei_pkg::SEI_ST_CTRL_W;
            state <= sei_pkg::SEI_START;
          end
        end
        sei_pkg::SEI_START: begin
          // clock low, data released, clock high, then data falls
          if (at_zero) begin
            scl_low <= 1'b1;
          end else if (at_rise) begin
            scl_low <= 1'b0;
          end
          if (at_hold) begin
            sda_low <= 1'b0;
          end else if (at_mid) begin
            sda_low <= 1'b1;
          end
          if (start_end) begin
            state <= sei_pkg::SEI_LOAD;
          end
        end
        sei_pkg::SEI_LOAD: begin
          // clock held low while the write buffer runs dry
          scl_low <= 1'b1;
          cnt <= 8'h00;
          if (load_go) begin
            tx <= next_tx;
            bit_idx <= 4'h0;
            state <= sei_pkg::SEI_BIT;
          end
        end
        sei_pkg::SEI_BIT: begin
          if (at_zero) begin
            scl_low <= 1'b1;
          end else if (at_rise) begin
            scl_low <= 1'b0;
          end
          if (at_hold) begin
            sda_low <= !tx[8];
          end
          if (bit_end) begin
            rx <= rx_next;
            tx <= {tx[7:0], 1'b1};
            cnt <= 8'h00;
            bit_idx <= 4'(bit_idx + 4'h1);
            if (bit_idx == 4'h8) begin
              case (stage)
                sei_pkg::SEI_ST_CTRL_W, sei_pkg::SEI_ST_POLL: begin
                  // silence on the control byte means busy programming
                  if (nack) begin
                    again <= 1'b1;
                    state <= sei_pkg::SEI_STOP;
                  end else if (stage == sei_pkg::SEI_ST_POLL) begin
                    again <= 1'b0;
                    state <= sei_pkg::SEI_STOP;
                  end else begin
                    stage <= sei_pkg::SEI_ST_ADDR;
                    state <= sei_pkg::SEI_LOAD;
                  end
                end
                sei_pkg::SEI_ST_ADDR, sei_pkg::SEI_ST_CTRL_R: begin
                  if (nack) begin
                    failed <= 1'b1;
                    again <= 1'b0;
                    state <= sei_pkg::SEI_STOP;
                  end else if (stage == sei_pkg::SEI_ST_CTRL_R) begin
                    stage <= sei_pkg::SEI_ST_RDATA;
                    state <= sei_pkg::SEI_LOAD;
                  end else if (op_write) begin
                    stage <= sei_pkg::SEI_ST_WDATA;
                    state <= sei_pkg::SEI_LOAD;
                  end else begin
                    stage <= sei_pkg::SEI_ST_CTRL_R;
                    state <= sei_pkg::SEI_START;
                  end
                end
                sei_pkg::SEI_ST_WDATA: begin
                  left <= 5'(left - 5'h01);
                  addr[3:0] <= 4'(addr[3:0] + 4'h1);
                  if (nack) begin
                    failed <= 1'b1;
                    again <= 1'b0;
                    state <= sei_pkg::SEI_STOP;
                  end else if (last) begin
                    stage <= sei_pkg::SEI_ST_POLL;
                    again <= 1'b1;
                    state <= sei_pkg::SEI_STOP;
                  end else begin
                    state <= sei_pkg::SEI_LOAD;
                  end
                end
                default: begin
                  rd_data_out <= rx_next[8:1];
                  rd_valid_out <= 1'b1;
                  left <= 5'(left - 5'h01);
                  if (last) begin
                    again <= 1'b0;
                    state <= sei_pkg::SEI_STOP;
                  end else begin
                    state <= sei_pkg::SEI_LOAD;
                  end
                end
              endcase
            end
          end
        end
        default: begin
          // stop: data low under low clock, clock high, data rises, bus free
          if (at_zero) begin
            scl_low <= 1'b1;
          end else if (at_rise) begin
            scl_low <= 1'b0;
          end
          if (at_hold) begin
            sda_low <= 1'b1;
          end else if (at_mid) begin
            sda_low <= 1'b0;
          end
          if (stop_end) begin
            cnt <= 8'h00;
            failed <= 1'b0;
            if (again) begin
              state <= sei_pkg::SEI_START;
            end else begin
              state <= sei_pkg::SEI_IDLE;
              err_out <= failed;
              done_out <= !failed;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  wire in_high = (state == sei_pkg::SEI_BIT) && (cnt > LOW) && (cnt < 8'(LOW + HIGH));
  wire ack_slot = (state == sei_pkg::SEI_BIT) && (bit_idx == 4'h8) && (cnt > HOLD);
  start_on_idle_a: assert property ((state == sei_pkg::SEI_IDLE) ##1
    (state == sei_pkg::SEI_START) |-> $past(scl_s && sda_s, 1))
    else $error("transfer started on a busy bus");
  data_stable_a: assert property (in_high |-> !scl_low && $stable(sda_low))
    else $error("data moved while clock high");
  start_form_a: assert property ((state == sei_pkg::SEI_START) && at_mid |=>
    sda_low && !scl_low && $past(!sda_low, 1))
    else $error("start not a falling data edge under high clock");
  stop_form_a: assert property ((state == sei_pkg::SEI_STOP) && at_mid |=>
    !sda_low && !scl_low ##1 !sda_low)
    else $error("stop not a rising data edge under high clock");
  ack_release_a: assert property (ack_slot && (stage != sei_pkg::SEI_ST_RDATA)
    |-> !sda_low)
    else $error("master held data in the device ack slot");
  master_ack_a: assert property (ack_slot && (stage == sei_pkg::SEI_ST_RDATA)
    |-> sda_low == (left != 5'h01))
    else $error("wrong master ack on read");
  ctrl_code_a: assert property ((state == sei_pkg::SEI_BIT) && (bit_idx == 4'h0)
    && is_ctrl |-> (tx[8:5] == `SEI_CTRL_CODE) && (tx[1] == stage_rd))
    else $error("bad control byte");
  page_guard_a: assert property (cmd_fire && cmd_write_in && page_cross |=>
    err_out && (state == sei_pkg::SEI_IDLE))
    else $error("page crossing write not refused");
  poll_after_a: assert property ((state == sei_pkg::SEI_BIT) && bit_end
    && (bit_idx == 4'h8) && (stage == sei_pkg::SEI_ST_WDATA) && !nack && last
    |=> (state == sei_pkg::SEI_STOP) ##[1:200] (state == sei_pkg::SEI_START))
    else $error("no poll after write stop");
  write_done_a: assert property (done_out && op_write |->
    (stage == sei_pkg::SEI_ST_POLL))
    else $error("write finished without an acked poll");
  write_seen_c: cover property (done_out && op_write);
  read_seen_c: cover property (done_out && !op_write);
  busy_poll_c: cover property (ack_slot && bit_end && nack && (stage == sei_pkg::SEI_ST_POLL));
  fail_seen_c: cover property (err_out && !cmd_fire);

endmodule : sei_master

// ==== sei_master_test.sv ====
`define SEI_CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD %0t got %h want %h", $time, (got), (exp)); end end

module sei_master_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // signals, bus wiring and instances
  // ----------------------------------------
  localparam int WRITE_CYCLES = 2000;
  localparam int CEILING = 95000;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic cmd_valid_in = 1'b0, cmd_write_in = 1'b0, wr_valid_in = 1'b0, write_inhibit_in = 1'b0;
  logic [8:0] cmd_addr_in = '0;
  logic [4:0] cmd_len_in = '0;
  logic [7:0] wr_data_in = '0;
  logic cmd_ready_out, wr_ready_out, rd_valid_out, done_out, err_out, busy_out;
  logic write_inhibit_out, scl_out, scl_oe_n_out, sda_out, sda_oe_n_out, dev_oe_n;
  logic [7:0] rd_data_out;
  int err_count = 0, total_checks = 0, cycles = 0, rcount;
  logic [7:0] shadow [512];
  logic [7:0] rbuf [32];
  logic got_err;
  // pull-ups: a released line reads high, any puller wins
  wire scl = scl_oe_n_out;
  wire sda = sda_oe_n_out & dev_oe_n;

  sei_master uut (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_write_in(cmd_write_in),
    .cmd_addr_in(cmd_addr_in), .cmd_len_in(cmd_len_in), .wr_data_in(wr_data_in),
    .wr_valid_in(wr_valid_in), .wr_ready_out(wr_ready_out), .rd_data_out(rd_data_out),
    .rd_valid_out(rd_valid_out), .done_out(done_out), .err_out(err_out), .busy_out(busy_out),
    .write_inhibit_in(write_inhibit_in), .write_inhibit_out(write_inhibit_out),
    .scl_in(scl), .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out),
    .sda_in(sda), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out));

  sei_eeprom_model #(.WRITE_CYCLES(WRITE_CYCLES)) dev (.clk_in(clk_in),
    .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda), .wp_in(write_inhibit_out),
    .sda_oe_n_out(dev_oe_n));

  // clock and hang guard; a hang counts as a mismatch
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      err_count++;
      $display("BAD %0t run did not finish", $time);
      test_done();
    end
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  // push one byte, held until the buffer takes it
  task automatic push(input logic [7:0] b);
    @(posedge clk_in);
    wr_data_in <= b;
    wr_valid_in <= 1'b1;
    @(negedge clk_in);
    for (int i = 0; i < 20000 && !wr_ready_out; i++) @(negedge clk_in);
    @(posedge clk_in);
    wr_valid_in <= 1'b0;
  endtask : push

  // issue one command, collect read bytes until done or error
  task automatic run_cmd(input logic wr, input logic [8:0] a, input logic [4:0] n);
    @(posedge clk_in);
    cmd_write_in <= wr;
    cmd_addr_in <= a;
    cmd_len_in <= n;
    cmd_valid_in <= 1'b1;
    @(negedge clk_in);
    for (int i = 0; i < 500 && !cmd_ready_out; i++) @(negedge clk_in);
    @(posedge clk_in);
    cmd_valid_in <= 1'b0;
    rcount = 0;
    got_err = 1'b0;
    for (int i = 0; i < 40000; i++) begin
      @(negedge clk_in);
      if (rd_valid_out === 1'b1 && rcount < 32) begin
        rbuf[rcount] = rd_data_out;
        rcount++;
      end
      if (done_out === 1'b1 || err_out === 1'b1) begin
        got_err = err_out;
        break;
      end
    end
  endtask : run_cmd

  // read back and compare against the shadow image
  task automatic rd_check(input logic [8:0] a, input logic [4:0] n);
    run_cmd(1'b0, a, n);
    `SEI_CHK(got_err, 1'b0)
    `SEI_CHK(rcount, int'(n))
    for (int i = 0; i < n; i++) `SEI_CHK(rbuf[i], shadow[9'(a + i)])
  endtask : rd_check

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // page-crossing and empty writes: refused, bus stays idle
  task automatic t_refuse;
    logic [8:0] ad [2] = '{9'h0fd, 9'h030};
    logic [4:0] ln [2] = '{5'h4, 5'h0};
    for (int k = 0; k < 2; k++) begin
      run_cmd(1'b1, ad[k], ln[k]);
      `SEI_CHK(got_err, 1'b1)
      repeat (40) @(negedge clk_in);
      `SEI_CHK({scl, sda, busy_out}, 3'h6)
      `SEI_CHK({scl_out, sda_out}, 2'h0)
    end
    $display("refuse test finished");
  endtask : t_refuse

  // byte write to upper half; data arrives late so the engine stalls
  task automatic t_byte_write;
    int t0;
    fork
      run_cmd(1'b1, 9'h105, 5'h1);
      begin
        repeat (2500) @(posedge clk_in);
        push(8'hc3);
        // programming time counts from the data byte, not the stall
        t0 = cycles;
      end
    join
    shadow[9'h105] = 8'hc3;
    `SEI_CHK(got_err, 1'b0)
    `SEI_CHK(cycles - t0 > WRITE_CYCLES, 1'b1)
    rd_check(9'h105, 5'h1);
    rd_check(9'h005, 5'h1);
    $display("byte write test finished");
  endtask : t_byte_write

  // full page: buffer filled until it refuses, then drained
  task automatic t_page_write;
    for (int i = 0; i < 16; i++) begin
      push(8'(i * 37 + 1));
      shadow[9'h020 + i] = 8'(i * 37 + 1);
    end
    @(negedge clk_in);
    `SEI_CHK(wr_ready_out, 1'b0)
    run_cmd(1'b1, 9'h020, 5'h10);
    `SEI_CHK(got_err, 1'b0)
    `SEI_CHK(wr_ready_out, 1'b1)
    rd_check(9'h020, 5'h10);
    $display("page write test finished");
  endtask : t_page_write

  // strap high: write completes but memory keeps old value
  task automatic t_inhibit;
    @(posedge clk_in);
    write_inhibit_in <= 1'b1;
    push(8'h77);
    run_cmd(1'b1, 9'h040, 5'h1);
    `SEI_CHK(write_inhibit_out, 1'b1)
    `SEI_CHK(got_err, 1'b0)
    rd_check(9'h040, 5'h1);
    @(posedge clk_in);
    write_inhibit_in <= 1'b0;
    $display("inhibit test finished");
  endtask : t_inhibit

  // sequential read running across the half boundary
  task automatic t_seq_read;
    rd_check(9'h0ff, 5'h3);
    $display("sequential read test finished");
  endtask : t_seq_read

  // ----------------------------------------
  // main sequence and verdict
  // ----------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  initial begin
    for (int i = 0; i < 512; i++) shadow[i] = i[7:0] ^ 8'h5a;
    repeat (12) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_refuse();
    t_byte_write();
    t_page_write();
    t_inhibit();
    t_seq_read();
    test_done();
  end
endmodule : sei_master_test

// ==== sei_pkg.sv ====
// ----------------------------------------
// shared types
// ----------------------------------------
package sei_pkg;

  // bus engine states
  typedef enum logic [2:0] {
    SEI_IDLE,
    SEI_START,
    SEI_LOAD,
    SEI_BIT,
    SEI_STOP
  } sei_state_t;

  // which byte of a transfer is on the wire
  typedef enum logic [2:0] {
    SEI_ST_CTRL_W,
    SEI_ST_ADDR,
    SEI_ST_WDATA,
    SEI_ST_CTRL_R,
    SEI_ST_RDATA,
    SEI_ST_POLL
  } sei_stage_t;

endpackage : sei_pkg

// ==== sei_sync.sv ====
// ----------------------------------------
// two-flop synchroniser for bus pins
// ----------------------------------------
module sei_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // pins in, synchronised out
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta;

  // idle bus reads high, so reset to ones
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      meta <= '1;
      q_out <= '1;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule : sei_sync
